/* src/prts_map.svh */
// Purpose: Register offsets, field positions, reset values and timing figures of the sequencer.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register.
// Notes:   Definitions only.
`ifndef PRTS_MAP_SVH
`define PRTS_MAP_SVH

// ********************************************************************
// Sizes
// ********************************************************************
`define PRTS_NRAIL       12
`define PRTS_VW          12
`define PRTS_NGPI        4

// ********************************************************************
// Global register offsets
// ********************************************************************
`define PRTS_GCTRL       9'h000
`define PRTS_GSTAT       9'h004
`define PRTS_ALERT       9'h008
`define PRTS_RAIL_BASE   9'h040
`define PRTS_RAIL_LAST   9'h1bc

// ********************************************************************
// Per-rail word offsets, rail block stride is 32 bytes
// ********************************************************************
`define PRTS_W_CFG       3'h0
`define PRTS_W_DEP       3'h1
`define PRTS_W_TIM       3'h2
`define PRTS_W_PG        3'h3
`define PRTS_W_UV        3'h4
`define PRTS_W_OV        3'h5
`define PRTS_W_TOFF      3'h6
`define PRTS_W_STAT      3'h7

// ********************************************************************
// Field positions
// ********************************************************************
`define PRTS_G_AUTO      0
`define PRTS_G_OPON      1
`define PRTS_G_SAVE      2
`define PRTS_C_HASMON    8
`define PRTS_C_HASEN     9

// ********************************************************************
// Reset values
// ********************************************************************
`define PRTS_RST_AUTO    1'b0
`define PRTS_RST_PGON    12'h800
`define PRTS_RST_PGOFF   12'h700
`define PRTS_RST_OV      12'hfff

// ********************************************************************
// Timing
// ********************************************************************
`define PRTS_CLK_MHZ     50
`define PRTS_MS_US       1000
`define PRTS_SAMPLE_US   400
`define PRTS_DELAY_MAX   12'hccc

`endif

/* src/prts_pkg.sv */
// Purpose: Types shared by the power rail turn-on sequencer.
// Assumes: prts_map.svh supplies the sizes.
// Notes:   All sequencer state lives in prts_state_s.
`include "prts_map.svh"

package prts_pkg;

	typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_DELAY, ST_RAMP, ST_ON, ST_STOP, ST_DRAIN} prts_state_e;
	typedef enum logic [1:0] {RESP_RESTART, RESP_OFF_NOW, RESP_SEQ_OFF, RESP_GROUP} prts_resp_e;
	typedef enum logic [1:0] {FLT_UV, FLT_OV, FLT_TON, FLT_TOFF} prts_flt_e;

	typedef logic [`PRTS_VW-1:0]    prts_v_t;
	typedef logic [`PRTS_NRAIL-1:0] prts_mask_t;

	typedef struct packed {
		logic        monOnly;
		logic        usePar;
		logic        useGpi;
		logic        gpiLvl;
		logic [1:0]  gpiSel;
		prts_resp_e  resp;
		logic        hasMon;
		logic        hasEn;
		prts_mask_t  par;
		prts_mask_t  slv;
		logic [11:0] delayMs;
		logic [11:0] tonMaxMs;
		prts_v_t     pgOn;
		prts_v_t     pgOff;
		prts_v_t     uvFlt;
		prts_v_t     uvWrn;
		prts_v_t     ovWrn;
		prts_v_t     ovFlt;
		logic [11:0] toffMs;
		prts_state_e st;
		logic [11:0] cnt;
		logic [15:0] subCnt;
		logic        pg;
		logic        hold;
		logic        uvW;
		logic        ovW;
		logic        flt;
		prts_flt_e   lastFlt;
	} prts_rail_s;

	typedef struct packed {
		prts_rail_s [`PRTS_NRAIL-1:0] rail;
		prts_mask_t                   enOut;
		logic                         autoEn;
		logic                         opOn;
		logic                         pinS1;
		logic                         pinS2;
		logic [`PRTS_NGPI-1:0]        gpiS1;
		logic [`PRTS_NGPI-1:0]        gpiS2;
		logic                         ack;
		logic [31:0]                  rdata;
		logic [15:0]                  smpCnt;
		logic                         saveReq;
		logic                         logValid;
		logic [3:0]                   logRail;
		prts_flt_e                    logType;
		logic                         alert;
	} prts_state_s;

endpackage

/* src/prts_sequencer.sv */
// Purpose: Sequences up to twelve supply rails on and off and watches them while on.
// Assumes: railVolt carries fresh ADC codes in the clk domain; one 50 MHz clock.
// Notes:   Registers sit on an Avalon-MM slave that answers one cycle after a request.
//
// Function
// - Drive one enable output per rail, up to twelve rails, high to turn on.
// - Either the control pin or the OPERATION on bit starts sequence-on.
// - The control pin alone sequences rails on and, when dropped, off.
// - Auto-enable ignores pin and OPERATION; rails sequence on after reset. Here auto-enable resets to 0, so rails sequence on only once it is written.
// - Power good sets at the on threshold, clears only below the off threshold.
// - A rail in regulation is checked against UV and OV warn and fault limits.
// - A fault applies its response: restart, off now, sequenced off, or group restart.
// - A monitor-only rail never has its enable driven.
// - A rail may wait a fixed delay after the on trigger.
// - A rail may wait a fixed delay after its parent rails are power good.
// - A rail may wait on a general input level; conditions may be combined.
// - Turn-on delay reaches 3276 ms at most.
// - Enable is withheld until every selected rail and input dependency holds.
// - Too long to reach power good on or off after a switch is a fault.
// - A faulting rail also turns off its fault-shutdown slaves.
// - Each rail has at least a monitor or an enable output.
// - Bus configuration lives in working registers and can be saved to flash.
// - Rail status is kept and each fault is passed to the flash fault log. Here only the lowest rail's fault of those in one cycle is logged.
// - The management bus runs at 100 kHz or 400 kHz.
// - An alert output signals pending status to the bus master.
// - Maximum turn-on time counts in 1 ms steps; zero means no limit.
// - Rail measurements are evaluated every 400 microseconds.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "prts_map.svh"

module prts_sequencer #(
	parameter int MS_CYC  = `PRTS_MS_US * `PRTS_CLK_MHZ,
	parameter int SMP_CYC = `PRTS_SAMPLE_US * `PRTS_CLK_MHZ
) (
	input  logic                               clk,
	input  logic                               reset,
	input  logic [8:0]                         avs_address,
	input  logic                               avs_read,
	input  logic                               avs_write,
	input  logic [31:0]                        avs_writedata,
	input  logic [3:0]                         avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	input  logic                               sequenceControlPin,
	input  logic [`PRTS_NGPI-1:0]              generalInput,
	input  logic [`PRTS_NRAIL*`PRTS_VW-1:0]    railVolt,
	output prts_pkg::prts_mask_t               railEnable,
	output logic                               configSaveReq,
	output logic                               faultLogValid,
	output logic [3:0]                         faultLogRail,
	output prts_pkg::prts_flt_e                faultLogType,
	output logic                               alertOut,
	output logic                               alertOe
);
	import prts_pkg::*;

	localparam int NR = `PRTS_NRAIL;
	localparam int VW = `PRTS_VW;

	prts_state_s q, d;
	prts_rail_s  r, n;
	prts_mask_t  fv, kill, killHold, pgVec;
	prts_flt_e   ft [NR];
	prts_v_t     v;
	logic [31:0] wWord, cWord;
	logic [4:0]  wIdx;
	logic        seqOn, smpTick, msTick, depOk, busWr;

	// ********************************************************************
	// Helpers
	// ********************************************************************
	function automatic logic [31:0] beMask(input logic [3:0] be);
		beMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic isRail(input logic [8:0] a);
		isRail = (a >= `PRTS_RAIL_BASE) && (a <= `PRTS_RAIL_LAST);
	endfunction

	function automatic logic [4:0] railIdx(input logic [8:0] a);
		logic [8:0] off;
		off = a - `PRTS_RAIL_BASE;
		railIdx = off[8:4] >> 1;
	endfunction

	// Delays above 3276 ms are held at that longest legal value.
	function automatic logic [11:0] clampMs(input logic [11:0] x);
		clampMs = (x > `PRTS_DELAY_MAX) ? `PRTS_DELAY_MAX : x;
	endfunction

	function automatic logic [31:0] rdWord(input prts_state_s s, input logic [8:0] a);
		prts_rail_s x;
		logic [4:0] i;
		i = railIdx(a);
		x = s.rail[i[3:0]];
		rdWord = 32'h0;
		if (a == `PRTS_GCTRL) begin
			rdWord = {30'h0, s.opOn, s.autoEn};
		end else if (a == `PRTS_GSTAT) begin
			rdWord = {4'h0, pgVecOf(s), 4'h0, s.enOut};
		end else if (a == `PRTS_ALERT) begin
			rdWord = {31'h0, s.alert};
		end else if (isRail(a)) begin
			unique case (a[4:2])
				`PRTS_W_CFG:  rdWord = {22'h0, x.hasEn, x.hasMon, x.resp, x.gpiSel,
					x.gpiLvl, x.useGpi, x.usePar, x.monOnly};
				`PRTS_W_DEP:  rdWord = {4'h0, x.slv, 4'h0, x.par};
				`PRTS_W_TIM:  rdWord = {4'h0, x.tonMaxMs, 4'h0, x.delayMs};
				`PRTS_W_PG:   rdWord = {4'h0, x.pgOff, 4'h0, x.pgOn};
				`PRTS_W_UV:   rdWord = {4'h0, x.uvWrn, 4'h0, x.uvFlt};
				`PRTS_W_OV:   rdWord = {4'h0, x.ovFlt, 4'h0, x.ovWrn};
				`PRTS_W_TOFF: rdWord = {20'h0, x.toffMs};
				`PRTS_W_STAT: rdWord = {18'h0, x.lastFlt, 1'b0, x.st, 3'h0,
					s.enOut[i[3:0]], x.pg, x.flt, x.ovW, x.uvW};
			endcase
		end
	endfunction

	function automatic prts_mask_t pgVecOf(input prts_state_s s);
		for (int k = 0; k < NR; k++) begin
			pgVecOf[k] = s.rail[k].pg;
		end
	endfunction

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		d        = q;
		r        = q.rail[0];
		n        = q.rail[0];
		fv       = '0;
		kill     = '0;
		killHold = '0;
		v        = '0;
		msTick   = 1'b0;
		depOk    = 1'b0;
		ft       = '{default: FLT_UV};
		pgVec = pgVecOf(q);
		d.saveReq  = 1'b0;
		d.logValid = 1'b0;
		d.pinS1    = sequenceControlPin;
		d.pinS2    = q.pinS1;
		d.gpiS1    = generalInput;
		d.gpiS2    = q.gpiS1;
		smpTick  = q.smpCnt == 16'(SMP_CYC - 1);
		d.smpCnt = smpTick ? 16'h0 : q.smpCnt + 16'h1;
		// Auto-enable holds the sequence request high regardless of pin and command.
		seqOn = q.autoEn ? 1'b1 : (q.opOn | q.pinS2);
		// The slave stretches each access by one cycle so that read data comes from a
		// flop and the management front end sees a fixed turnaround at any bus rate.
		d.ack = (avs_read | avs_write) & ~q.ack;
		if (avs_read && !q.ack) begin
			d.rdata = rdWord(q, avs_address);
		end
		busWr = avs_write & q.ack;
		wWord = (rdWord(q, avs_address) & ~beMask(avs_byteenable))
			| (avs_writedata & beMask(avs_byteenable));
		cWord = avs_writedata & beMask(avs_byteenable);
		wIdx  = railIdx(avs_address);
		// ********************************************************************
		// Register writes
		// ********************************************************************
		if (busWr) begin
			if (avs_address == `PRTS_GCTRL) begin
				d.autoEn  = wWord[`PRTS_G_AUTO];
				d.opOn    = wWord[`PRTS_G_OPON];
				d.saveReq = cWord[`PRTS_G_SAVE];
			end else if (isRail(avs_address)) begin
				unique case (avs_address[4:2])
					`PRTS_W_CFG: begin
						d.rail[wIdx[3:0]].monOnly = wWord[0];
						d.rail[wIdx[3:0]].usePar  = wWord[1];
						d.rail[wIdx[3:0]].useGpi  = wWord[2];
						d.rail[wIdx[3:0]].gpiLvl  = wWord[3];
						d.rail[wIdx[3:0]].gpiSel  = wWord[5:4];
						d.rail[wIdx[3:0]].resp    = prts_resp_e'(wWord[7:6]);
						d.rail[wIdx[3:0]].hasEn   = wWord[`PRTS_C_HASEN];
						// A rail with neither monitor nor enable would be empty.
						d.rail[wIdx[3:0]].hasMon  = wWord[`PRTS_C_HASMON]
							| ~wWord[`PRTS_C_HASEN];
					end
					`PRTS_W_DEP: begin
						d.rail[wIdx[3:0]].par = wWord[11:0];
						d.rail[wIdx[3:0]].slv = wWord[27:16];
					end
					`PRTS_W_TIM: begin
						d.rail[wIdx[3:0]].delayMs  = clampMs(wWord[11:0]);
						d.rail[wIdx[3:0]].tonMaxMs = wWord[27:16];
					end
					`PRTS_W_PG: begin
						d.rail[wIdx[3:0]].pgOn  = wWord[11:0];
						d.rail[wIdx[3:0]].pgOff = wWord[27:16];
					end
					`PRTS_W_UV: begin
						d.rail[wIdx[3:0]].uvFlt = wWord[11:0];
						d.rail[wIdx[3:0]].uvWrn = wWord[27:16];
					end
					`PRTS_W_OV: begin
						d.rail[wIdx[3:0]].ovWrn = wWord[11:0];
						d.rail[wIdx[3:0]].ovFlt = wWord[27:16];
					end
					`PRTS_W_TOFF: begin
						d.rail[wIdx[3:0]].toffMs = clampMs(wWord[11:0]);
					end
					`PRTS_W_STAT: begin
						d.rail[wIdx[3:0]].uvW = q.rail[wIdx[3:0]].uvW & ~cWord[0];
						d.rail[wIdx[3:0]].ovW = q.rail[wIdx[3:0]].ovW & ~cWord[1];
						d.rail[wIdx[3:0]].flt = q.rail[wIdx[3:0]].flt & ~cWord[2];
					end
				endcase
			end
		end
		// ********************************************************************
		// Fault detection
		// ********************************************************************
		for (int i = 0; i < NR; i++) begin
			r      = q.rail[i];
			v      = railVolt[i*VW +: VW];
			msTick = r.subCnt == 16'(MS_CYC - 1);
			if (r.st == ST_ON && r.hasMon && r.pg && smpTick) begin
				if (v < r.uvFlt) begin
					fv[i] = 1'b1;
					ft[i] = FLT_UV;
				end else if (v > r.ovFlt) begin
					fv[i] = 1'b1;
					ft[i] = FLT_OV;
				end
			end
			if (r.tonMaxMs != 12'h0 && msTick && r.cnt == 12'h1) begin
				if (r.st == ST_RAMP) begin
					fv[i] = 1'b1;
					ft[i] = FLT_TON;
				end else if (r.st == ST_DRAIN) begin
					fv[i] = 1'b1;
					ft[i] = FLT_TOFF;
				end
			end
			if (fv[i]) begin
				kill     = kill | r.slv;
				killHold = killHold | (r.resp == RESP_GROUP ? '0 : r.slv);
			end
		end
		// ********************************************************************
		// Rail sequencing
		// ********************************************************************
		for (int i = 0; i < NR; i++) begin
			r      = q.rail[i];
			n      = d.rail[i];
			v      = railVolt[i*VW +: VW];
			msTick = r.subCnt == 16'(MS_CYC - 1);
			depOk  = (!r.usePar || ((r.par & pgVec) == r.par))
				&& (!r.useGpi || q.gpiS2[r.gpiSel] == r.gpiLvl);
			n.subCnt = msTick ? 16'h0 : r.subCnt + 16'h1;
			n.cnt    = (msTick && r.cnt != 12'h0) ? r.cnt - 12'h1 : r.cnt;
			if (smpTick) begin
				if (!r.hasMon) begin
					n.pg = r.st inside {ST_RAMP, ST_ON, ST_STOP};
				end else begin
					n.pg = r.pg ? (v >= r.pgOff) : (v >= r.pgOn);
				end
				if (r.st == ST_ON && r.hasMon && r.pg) begin
					n.uvW = n.uvW | (v < r.uvWrn);
					n.ovW = n.ovW | (v > r.ovWrn);
				end
			end
			if (fv[i]) begin
				n.flt     = 1'b1;
				n.lastFlt = ft[i];
			end
			if (kill[i] && r.st inside {ST_WAIT, ST_DELAY}) begin
				n.st   = ST_OFF;
				n.hold = r.hold | killHold[i];
			end else if (kill[i] && r.st inside {ST_RAMP, ST_ON}) begin
				n.st     = ST_STOP;
				n.cnt    = r.toffMs;
				n.subCnt = 16'h0;
				n.hold   = r.hold | killHold[i];
			end else begin
				unique case (r.st)
					ST_OFF: begin
						if (!seqOn) begin
							n.hold = 1'b0;
						end else if (!r.hold) begin
							n.st = ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (!seqOn) begin
							n.st = ST_OFF;
						end else if (depOk) begin
							n.st     = ST_DELAY;
							n.cnt    = r.delayMs;
							n.subCnt = 16'h0;
						end
					end
					ST_DELAY: begin
						if (!seqOn) begin
							n.st = ST_OFF;
						end else if (!depOk) begin
							n.st = ST_WAIT;
						end else if (r.cnt == 12'h0) begin
							n.st     = ST_RAMP;
							n.cnt    = r.tonMaxMs;
							n.subCnt = 16'h0;
						end
					end
					ST_RAMP, ST_ON: begin
						if (fv[i]) begin
							// Restart and group responses leave hold clear so the rail
							// comes back through its normal turn-on conditions.
							n.hold = r.resp inside {RESP_OFF_NOW, RESP_SEQ_OFF};
							if (r.resp == RESP_SEQ_OFF) begin
								n.st  = ST_STOP;
								n.cnt = r.toffMs;
							end else begin
								n.st  = ST_DRAIN;
								n.cnt = r.tonMaxMs;
							end
							n.subCnt = 16'h0;
						end else if (!seqOn) begin
							n.st     = ST_STOP;
							n.cnt    = r.toffMs;
							n.subCnt = 16'h0;
						end else if (r.st == ST_RAMP && r.pg) begin
							n.st = ST_ON;
						end
					end
					ST_STOP: begin
						if (r.cnt == 12'h0) begin
							n.st     = ST_DRAIN;
							n.cnt    = r.tonMaxMs;
							n.subCnt = 16'h0;
						end
					end
					ST_DRAIN: begin
						if (fv[i] || !r.pg) begin
							n.st = ST_OFF;
						end
					end
				endcase
			end
			d.enOut[i] = (n.st inside {ST_RAMP, ST_ON, ST_STOP})
				&& n.hasEn && !n.monOnly;
			d.rail[i]  = n;
		end
		// ********************************************************************
		// Fault log and alert
		// ********************************************************************
		// Lowest rail wins when several fault together; the rest stay visible in status.
		for (int i = NR - 1; i >= 0; i--) begin
			if (fv[i]) begin
				d.logValid = 1'b1;
				d.logRail  = 4'(i);
				d.logType  = ft[i];
			end
		end
		d.alert = 1'b0;
		for (int i = 0; i < NR; i++) begin
			d.alert = d.alert | d.rail[i].flt | d.rail[i].uvW | d.rail[i].ovW;
		end
		if (reset) begin
			d        = '0;
			d.autoEn = `PRTS_RST_AUTO;
			for (int i = 0; i < NR; i++) begin
				d.rail[i].hasMon = 1'b1;
				d.rail[i].hasEn  = 1'b1;
				d.rail[i].pgOn   = `PRTS_RST_PGON;
				d.rail[i].pgOff  = `PRTS_RST_PGOFF;
				d.rail[i].ovWrn  = `PRTS_RST_OV;
				d.rail[i].ovFlt  = `PRTS_RST_OV;
			end
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
	assign avs_readdata    = q.rdata;
	assign railEnable      = q.enOut;
	assign configSaveReq   = q.saveReq;
	assign faultLogValid   = q.logValid;
	assign faultLogRail    = q.logRail;
	assign faultLogType    = q.logType;
	// Open-drain alert: the pin is pulled low only while status is pending.
	assign alertOut        = 1'b0;
	assign alertOe         = q.alert;

endmodule

/* verif/prts_seq_properties.sv */
// Purpose: Port-level checks of the rail sequencer.
// Assumes: One clock and a synchronous active-high reset.
// Notes:   Bound to every sequencer instance from the bench top.
`timescale 1ns/10ps
`include "prts_map.svh"

module prts_seq_properties (
	input logic                 clk,
	input logic                 reset,
	input logic [8:0]           avs_address,
	input logic                 avs_read,
	input logic                 avs_write,
	input logic [31:0]          avs_writedata,
	input logic                 avs_waitrequest,
	input prts_pkg::prts_mask_t railEnable,
	input logic                 configSaveReq,
	input logic                 faultLogValid,
	input logic [3:0]           faultLogRail,
	input prts_pkg::prts_flt_e  faultLogType,
	input logic                 alertOut,
	input logic                 alertOe
);
	import prts_pkg::*;

	// ********
	// Handshake and event outputs
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_done;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	sequence s_save;
		s_done ##0 (avs_write && avs_address == `PRTS_GCTRL && avs_writedata[`PRTS_G_SAVE]);
	endsequence

	property p_answer;
		s_req |=> s_done;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
	property p_first;
		$rose(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_first: assert property (p_first) else $error("bus answered at once");
	property p_save;
		s_save |-> ##[1:2] configSaveReq;
	endproperty
	a_save: assert property (p_save) else $error("no save request");
	property p_save_pulse;
		configSaveReq |=> !configSaveReq;
	endproperty
	a_save_pulse: assert property (p_save_pulse) else $error("save request too long");
	property p_log_pulse;
		faultLogValid |=> !faultLogValid;
	endproperty
	a_log_pulse: assert property (p_log_pulse) else $error("log pulse too long");
	property p_log_hold;
		!faultLogValid |-> $stable(faultLogRail) && $stable(faultLogType);
	endproperty
	a_log_hold: assert property (p_log_hold) else $error("log data moved");
	property p_alert_data;
		alertOut == 1'b0;
	endproperty
	a_alert_data: assert property (p_alert_data) else $error("alert data high");
	property p_alert_log;
		faultLogValid |-> ##[0:2] alertOe;
	endproperty
	a_alert_log: assert property (p_alert_log) else $error("fault without alert");
	property p_quiet;
		$fell(reset) |-> railEnable == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("rail on after reset");
endmodule

/* verif/prts_supply_model.sv */
// Purpose: Behavioural supplies answering the rail enables.
// Assumes: Codes slew 0x040 per cycle toward their target.
// Notes:   A sagging rail settles at 0x800 while enabled.
`timescale 1ns/10ps

module prts_supply_model (
	input wire logic            clk,
	input wire logic            reset,
	input prts_pkg::prts_mask_t railEnable,
	input prts_pkg::prts_mask_t sagMask,
	output logic [143:0]        railVolt
);
	import prts_pkg::*;

	// ********
	// Slewing outputs
	// ********
	logic [11:0][11:0] volt_q;

	// A supply never jumps, so power good comes some samples after enable.
	function automatic logic [11:0] target(input int i);
		return !railEnable[i] ? 12'h000 : (sagMask[i] ? 12'h800 : 12'hc00);
	endfunction

	assign railVolt = volt_q;

	always_ff @(posedge clk) begin
		for (int i = 0; i < 12; i++) begin
			if (reset)
				volt_q[i] <= 12'h000;
			else if (volt_q[i] < target(i))
				volt_q[i] <= volt_q[i] + 12'h040;
			else if (volt_q[i] > target(i))
				volt_q[i] <= volt_q[i] - 12'h040;
		end
	end
endmodule

/* verif/prts_sequencer_tb_top.sv */
// Purpose: Self-checking bench of the rail sequencer.
// Assumes: Short ms and sample counts; behavioural supplies.
// Notes:   Reads and fault logs are checked against expectation queues.
`timescale 1ns/10ps
`include "prts_map.svh"

module prts_sequencer_tb_top;
	import prts_pkg::*;

	logic         clk, reset, rd, wr, waitReq, pin, saveReq, logValid, alertOut, alertOe;
	logic [8:0]   addr;
	logic [31:0]  wdata, rdata, rnd;
	logic [3:0]   general_input, logRail;
	logic [143:0] volt;
	prts_mask_t   en, sag;
	prts_flt_e    logType;
	logic [31:0]  readQ[$], logQ[$];
	int           mismatches, totalChecks, cycles, lastWait;

	prts_sequencer #(.MS_CYC(20), .SMP_CYC(8)) i_dut (.clk(clk), .reset(reset),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitReq),
		.sequenceControlPin(pin), .generalInput(general_input), .railVolt(volt), .railEnable(en),
		.configSaveReq(saveReq), .faultLogValid(logValid), .faultLogRail(logRail),
		.faultLogType(logType), .alertOut(alertOut), .alertOe(alertOe));
	prts_supply_model i_supply (.clk(clk), .reset(reset), .railEnable(en), .sagMask(sag),
		.railVolt(volt));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ********
	// Checking
	// ********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic endOfTest;
		if (mismatches == 0 && totalChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (rd && waitReq === 1'b0)
			chk(rdata, readQ.size() > 0 ? readQ.pop_front() : 'x);
		if (logValid === 1'b1)
			chk(32'({logRail, logType}), logQ.size() > 0 ? logQ.pop_front() : 'x);
		if (cycles == 20000) begin
			mismatches++;
			endOfTest();
		end
	end

	// ********
	// Drivers
	// ********
	function automatic logic [8:0] ra(input int r, input logic [2:0] w);
		return 9'(`PRTS_RAIL_BASE + r * 32 + w * 4);
	endfunction

	// A read notes its expected data; the monitor compares it at completion.
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		if (!w)
			readQ.push_back(d);
		addr <= a;
		wdata <= w ? d : 32'h0;
		rd <= !w;
		wr <= w;
		@(posedge clk);
		// A slave that never answers is caught by the cycle ceiling in the monitor.
		while (waitReq !== 1'b0) begin
			@(posedge clk);
		end
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic waitEn(input prts_mask_t m, input prts_mask_t v);
		int n;
		n = 0;
		while ((en & m) !== v && n < 600) begin
			@(posedge clk);
			n++;
		end
		lastWait = n;
		chk(32'(en & m), 32'(v));
	endtask

	initial begin
		{rd, wr, pin, addr, wdata, general_input, sag} = '0;
		reset = 1'b1;
		rnd = $urandom(32'hc1d0);
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		bus(0, ra(0, `PRTS_W_CFG), 32'h300);
		bus(0, ra(0, `PRTS_W_PG), 32'h0700_0800);
		bus(1, 9'h010, 32'hffff_ffff);
		bus(0, 9'h010, 32'h0);
		bus(1, `PRTS_GCTRL, 32'h4);
		bus(0, `PRTS_GCTRL, 32'h0);
		bus(1, ra(5, `PRTS_W_TIM), 32'hfff);
		bus(0, ra(5, `PRTS_W_TIM), 32'hccc);
		rnd = $urandom & 32'h07ff_07ff;
		bus(1, ra(11, `PRTS_W_PG), rnd);
		bus(0, ra(11, `PRTS_W_PG), rnd);
		bus(1, ra(10, `PRTS_W_CFG), 32'h0);
		bus(0, ra(10, `PRTS_W_CFG), 32'h100);
		bus(1, ra(0, `PRTS_W_TIM), 32'h4);
		bus(1, ra(1, `PRTS_W_TIM), 32'h2);
		bus(1, ra(3, `PRTS_W_TIM), 32'h1);
		bus(1, ra(2, `PRTS_W_CFG), 32'h301);
		bus(1, ra(3, `PRTS_W_CFG), 32'h302);
		bus(1, ra(3, `PRTS_W_DEP), 32'h2);
		bus(1, ra(4, `PRTS_W_CFG), 32'h30c);
		bus(1, ra(6, `PRTS_W_CFG), 32'h340);
		bus(1, ra(6, `PRTS_W_TIM), 32'h0001_0000);
		bus(1, ra(0, `PRTS_W_DEP), 32'h0080_0000);
		logQ.push_back(32'({4'd6, FLT_TON}));
		pin <= 1'b1;
		waitEn(12'h00b, 12'h002);
		waitEn(12'h001, 12'h001);
		chk(lastWait, 40);
		waitEn(12'h018, 12'h008);
		general_input <= 4'h1;
		waitEn(12'h014, 12'h010);
		// Let the rail settle well above the limit before arming it.
		repeat (64) @(posedge clk);
		chk(alertOe, 1'b1);
		bus(0, ra(6, `PRTS_W_STAT), 32'h2004);
		bus(1, ra(6, `PRTS_W_STAT), 32'h4);
		bus(0, `PRTS_ALERT, 32'h0);
		bus(1, ra(0, `PRTS_W_UV), 32'h900);
		logQ.push_back(32'({4'd0, FLT_UV}));
		sag <= 12'h001;
		waitEn(12'h081, 12'h000);
		sag <= 12'h000;
		bus(1, ra(0, `PRTS_W_UV), 32'h0);
		waitEn(12'h081, 12'h001);
		pin <= 1'b0;
		waitEn(12'hfff, 12'h000);
		logQ.push_back(32'({4'd6, FLT_TON}));
		bus(1, `PRTS_GCTRL, 32'h2);
		waitEn(12'h002, 12'h002);
		bus(1, `PRTS_GCTRL, 32'h0);
		waitEn(12'hfff, 12'h000);
		logQ.push_back(32'({4'd6, FLT_TON}));
		bus(1, `PRTS_GCTRL, 32'h1);
		waitEn(12'h002, 12'h002);
		chk(32'(logQ.size()), 32'h0);
		endOfTest();
	end
endmodule

bind prts_sequencer prts_seq_properties i_props (.clk(clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.railEnable(railEnable), .configSaveReq(configSaveReq), .faultLogValid(faultLogValid),
	.faultLogRail(faultLogRail), .faultLogType(faultLogType), .alertOut(alertOut),
	.alertOe(alertOe));
